/* File: hw/wdt_timer.sv */
// Watchdog timer with shared prescaler and Avalon-MM register slave.
// Assumes all control inputs are synchronous to clock; one clock domain.
`timescale 1ns/1ps

// Behaviour
// - Time base from 31 kHz low-frequency oscillator.
// - Dedicated 16-bit prescaler ahead of counter.
// - Shared 8-bit prescaler, assign and rate select.
// - Time-out spans 1 ms to 270 s.
// - All resets load control with ---0 1000.
// - Reset control value gives 17 ms base.
// - Held in reset while start-up timer runs.
// - Resume after start-up only when enabled.
// - Stable flag unaffected by watchdog running.
// - Config enable runs watchdog, software cannot stop.
// - Software enable ignored when config enable set.
// - Otherwise software enable bit starts and stops.
// - Cleared when disabled, clear command, oscillator fail.
// - Cleared on wake with non-crystal clock.
// - Crystal wake: cleared until start-up timer ends.
module wdt_timer
  import wdt_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                srst,
  input  wire logic [4:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  output logic                     irq,
  input  wire logic                configWatchdogEnable,
  input  wire logic                clearWatchdogInstruction,
  input  wire logic                oscFailDetect,
  input  wire logic                sleepActive,
  input  wire logic                wakeFromSleep,
  input  wire logic [SYSCLK_W-1:0] sysClockMode,
  input  wire logic                oscStartupTimerRunning,
  input  wire logic                lfOscStableFlag,
  input  wire logic                generalTimerZeroTick,
  output logic                     generalTimerZeroPrescaledTick,
  output logic                     watchdogResetPulse,
  output logic                     watchdogWakePulse,
  output logic                     watchdogRunning
);

  typedef struct packed {
    logic [LF_DIV_W-1:0] lfDiv;
    logic                lfTick;
    logic [7:0]          ctrl;
    logic [7:0]          option;
    logic [IRQ_W-1:0]    irqStatus;
    logic [IRQ_W-1:0]    irqMask;
    wdt_run_t            run;
    logic                holdForOst;
    logic                prevOst;
    logic                prevPsa;
    logic                cmdClear;
    logic                waitReq;
    logic [31:0]         rdata;
    logic                irq;
    logic                resetPulse;
    logic                wakePulse;
    logic                t0Out;
    logic                runFlag;
  } wdt_state_t;

  wdt_state_t q;
  wdt_state_t d;

  // Address match shared by read and write decode
  function automatic logic addrHit(input logic [4:0] addr, input logic [4:0] offs);
    addrHit = (addr == offs);
  endfunction

  function automatic logic isCrystalMode(input logic [SYSCLK_W-1:0] mode);
    isCrystalMode = (mode == MODE_LP) || (mode == MODE_XT) || (mode == MODE_HS);
  endfunction

  logic                 preTick;
  logic                 postTick;
  logic                 preClear;
  logic                 postClear;
  logic                 postIn;
  logic [SEL_W-1:0]     preSel;
  logic [SEL_W-1:0]     postSel;
  logic [SEL_W-1:0]     selSum;
  logic                 prescaler_assign;
  logic [2:0]           rateSel;
  logic [3:0]           periodSel;
  logic                 enabled;
  logic                 crystalWake;
  logic                 plainWake;
  logic                 ostEnded;
  logic                 wdtClear;
  logic                 finalTick;
  logic                 timeout;
  logic                 reqTaken;
  logic                 wrDone;
  logic [IRQ_W-1:0]     irqSet;
  logic [IRQ_W-1:0]     irqW1c;

  // 16-bit dedicated prescaler on the low-frequency tick
  wdt_prescaler #(
    .WIDTH (PRE_WIDTH)
  ) u_pre (
    .clock   (clock),
    .srst    (srst),
    .clear   (preClear),
    .tickIn  (q.lfTick),
    .sel     (preSel),
    .tickOut (preTick)
  );

  // 8-bit prescaler shared with the general timer
  wdt_prescaler #(
    .WIDTH (POST_WIDTH)
  ) u_post (
    .clock   (clock),
    .srst    (srst),
    .clear   (postClear),
    .tickIn  (postIn),
    .sel     (postSel),
    .tickOut (postTick)
  );

  always_comb begin
    d = q;

    // Low-frequency oscillator tick, free running
    d.lfTick = 1'b0;
    if (q.lfDiv == LF_DIV_LAST) begin
      d.lfDiv  = '0;
      d.lfTick = 1'b1;
    end else begin
      d.lfDiv = q.lfDiv + 1'b1;
    end

    // Period select: 1:32 up to 1:65536, reset value 1:512
    prescaler_assign       = q.option[OPT_PSA_BIT];
    rateSel   = q.option[2:0];
    periodSel = q.ctrl[CTRL_PS_LSB +: 4];
    selSum    = PRE_BASE_LOG2 + {1'b0, periodSel};
    preSel    = (selSum > PRE_MAX_LOG2) ? PRE_MAX_LOG2 : selSum;

    // Watchdog side divides 1:1..1:128, timer side 1:2..1:256
    postSel = prescaler_assign ? {2'h0, rateSel} : SEL_W'({2'h0, rateSel} + 5'h01);
    postIn  = prescaler_assign ? preTick : generalTimerZeroTick;
    d.t0Out = prescaler_assign ? generalTimerZeroTick : postTick;
    d.prevPsa = prescaler_assign;

    // Enable: config bit overrides the software bit
    enabled = configWatchdogEnable | q.ctrl[CTRL_EN_BIT];

    // Sleep exit handling
    crystalWake = wakeFromSleep & isCrystalMode(sysClockMode);
    plainWake   = wakeFromSleep & ~isCrystalMode(sysClockMode);
    ostEnded    = q.prevOst & ~oscStartupTimerRunning;
    d.prevOst   = oscStartupTimerRunning;
    if (crystalWake) begin
      d.holdForOst = 1'b1;
    end else if (ostEnded) begin
      d.holdForOst = 1'b0;
    end

    // Any of these keeps the ripple counter cleared
    wdtClear = ~enabled
             | clearWatchdogInstruction
             | q.cmdClear
             | oscFailDetect
             | plainWake
             | crystalWake | q.holdForOst
             | oscStartupTimerRunning
             | q.resetPulse | q.wakePulse;

    preClear  = wdtClear;
    postClear = (prescaler_assign & wdtClear) | (prescaler_assign != q.prevPsa);

    // Run state; goes from HELD to RUNNING only once start-up ends and only if enabled
    if (!enabled) begin
      d.run = WDT_STOPPED;
    end else if (oscStartupTimerRunning || q.holdForOst || crystalWake) begin
      d.run = WDT_HELD;
    end else begin
      d.run = WDT_RUNNING;
    end
    // Registered copy so the running output leaves a flip-flop directly
    d.runFlag = (d.run == WDT_RUNNING);

    // Overflow of the selected chain
    finalTick = prescaler_assign ? postTick : preTick;
    timeout   = finalTick & (q.run == WDT_RUNNING) & ~wdtClear;
    d.resetPulse = timeout & ~sleepActive;
    d.wakePulse  = timeout & sleepActive;

    // Bus handshake: one wait cycle then one answer cycle
    reqTaken  = (avs_read | avs_write) & q.waitReq;
    wrDone    = avs_write & ~q.waitReq & avs_byteenable[0];
    d.waitReq = ~reqTaken;
    d.cmdClear = 1'b0;

    irqSet = '0;
    irqSet[IRQ_RESET_BIT] = d.resetPulse;
    irqSet[IRQ_WAKE_BIT]  = d.wakePulse;
    irqW1c = '0;

    if (wrDone) begin
      if (addrHit(avs_address, ADDR_CTRL)) begin
        d.ctrl = avs_writedata[7:0] & CTRL_IMPL_MASK;
      end
      if (addrHit(avs_address, ADDR_OPTION)) begin
        d.option = avs_writedata[7:0];
      end
      if (addrHit(avs_address, ADDR_IRQ_STATUS)) begin
        irqW1c = avs_writedata[IRQ_W-1:0];
      end
      if (addrHit(avs_address, ADDR_IRQ_MASK)) begin
        d.irqMask = avs_writedata[IRQ_W-1:0];
      end
      if (addrHit(avs_address, ADDR_COMMAND)) begin
        d.cmdClear = avs_writedata[CMD_CLEAR_BIT];
      end
    end

    // A watchdog reset is a reset source for the control register
    if (d.resetPulse) begin
      d.ctrl = RST_CTRL;
    end

    // New events win over a clear in the same cycle
    d.irqStatus = (q.irqStatus & ~irqW1c) | irqSet;
    d.irq       = |(d.irqStatus & d.irqMask);

    // Read data captured in the wait cycle, shown in the answer cycle
    d.rdata = '0;
    if (reqTaken && avs_read) begin
      if (addrHit(avs_address, ADDR_CTRL)) begin
        d.rdata[7:0] = q.ctrl;
      end
      if (addrHit(avs_address, ADDR_OPTION)) begin
        d.rdata[7:0] = q.option;
      end
      if (addrHit(avs_address, ADDR_IRQ_STATUS)) begin
        d.rdata[IRQ_W-1:0] = q.irqStatus;
      end
      if (addrHit(avs_address, ADDR_IRQ_MASK)) begin
        d.rdata[IRQ_W-1:0] = q.irqMask;
      end
      if (addrHit(avs_address, ADDR_STATUS)) begin
        d.rdata[STAT_RUN_BIT]    = (q.run == WDT_RUNNING);
        // Mirrors the input only; the watchdog never drives it
        d.rdata[STAT_LFSTAB_BIT] = lfOscStableFlag;
        d.rdata[STAT_HOLD_BIT]   = (q.run == WDT_HELD);
        d.rdata[STAT_CFGEN_BIT]  = configWatchdogEnable;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q            <= '0;
      q.ctrl       <= RST_CTRL;
      q.option     <= RST_OPTION;
      q.irqMask    <= RST_IRQ_MASK;
      q.run        <= WDT_STOPPED;
      q.waitReq    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata                  = q.rdata;
  assign avs_waitrequest               = q.waitReq;
  assign irq                           = q.irq;
  assign generalTimerZeroPrescaledTick = q.t0Out;
  assign watchdogResetPulse            = q.resetPulse;
  assign watchdogWakePulse             = q.wakePulse;
  assign watchdogRunning               = q.runFlag;

endmodule

/* File: hw/wdt_pkg.sv */
// Constants, register map and types of the watchdog timer block.
// Assumes a single 50 MHz clock; the low-frequency oscillator is derived from it.
package wdt_pkg;

  // Clock and low-frequency time base
  localparam int CLK_FREQ_KHZ    = 50000;
  localparam int LF_OSC_FREQ_KHZ = 31;
  localparam int LF_DIV_CYCLES   = CLK_FREQ_KHZ / LF_OSC_FREQ_KHZ;
  localparam int LF_DIV_W        = 11;
  localparam logic [LF_DIV_W-1:0] LF_DIV_LAST = LF_DIV_W'(LF_DIV_CYCLES - 1);

  // Prescaler shapes
  localparam int PRE_WIDTH  = 16;
  localparam int POST_WIDTH = 8;
  localparam int SEL_W      = 5;
  localparam logic [SEL_W-1:0] PRE_BASE_LOG2 = 5'h05;
  localparam logic [SEL_W-1:0] PRE_MAX_LOG2  = 5'h10;

  // Register byte offsets
  localparam logic [4:0] ADDR_CTRL       = 5'h00;
  localparam logic [4:0] ADDR_OPTION     = 5'h04;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h08;
  localparam logic [4:0] ADDR_IRQ_MASK   = 5'h0c;
  localparam logic [4:0] ADDR_STATUS     = 5'h10;
  localparam logic [4:0] ADDR_COMMAND    = 5'h14;

  // Watchdog control register
  localparam logic [7:0] RST_CTRL       = 8'h08;
  localparam logic [7:0] CTRL_IMPL_MASK = 8'h1f;
  localparam int         CTRL_EN_BIT    = 0;
  localparam int         CTRL_PS_LSB    = 1;

  // Option register
  localparam logic [7:0] RST_OPTION  = 8'hff;
  localparam int         OPT_PSA_BIT = 3;

  // Interrupt status and mask
  localparam int             IRQ_W         = 2;
  localparam int             IRQ_RESET_BIT = 0;
  localparam int             IRQ_WAKE_BIT  = 1;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 2'h0;

  // Command and status bits
  localparam int CMD_CLEAR_BIT    = 0;
  localparam int STAT_RUN_BIT     = 0;
  localparam int STAT_LFSTAB_BIT  = 1;
  localparam int STAT_HOLD_BIT    = 2;
  localparam int STAT_CFGEN_BIT   = 3;

  // System clock modes
  localparam int         SYSCLK_W    = 3;
  localparam logic [2:0] MODE_LP     = 3'h0;
  localparam logic [2:0] MODE_XT     = 3'h1;
  localparam logic [2:0] MODE_HS     = 3'h2;

  typedef enum logic [1:0] {WDT_STOPPED, WDT_HELD, WDT_RUNNING} wdt_run_t;

endpackage

/* File: hw/wdt_prescaler.sv */
// Power-of-two prescaler: divides an input tick by 2**sel.
// Assumes tickIn is a one-cycle pulse synchronous to clock.
`timescale 1ns/1ps
module wdt_prescaler
  import wdt_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             clear,
  input  wire logic             tickIn,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  tickOut
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             tickOut;
  } wdt_presc_state_t;

  wdt_presc_state_t q;
  wdt_presc_state_t d;
  logic [WIDTH-1:0] mask;

  always_comb begin
    d = q;
    d.tickOut = 1'b0;
    for (int i = 0; i < WIDTH; i++) begin
      mask[i] = (i < int'(sel));
    end
    if (clear) begin
      d.count = '0;
    end else if (tickIn) begin
      d.count = q.count + 1'b1;
      // Wraps on the selected low bits
      d.tickOut = &(q.count | ~mask);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tickOut = q.tickOut;

endmodule

/* File: dv/wdt_timer_properties.sv */
// Concurrent checks of the watchdog block, seen from its top-level ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module wdt_timer_properties (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        configWatchdogEnable,
  input wire logic        oscFailDetect,
  input wire logic        oscStartupTimerRunning,
  input wire logic        sleepActive,
  input wire logic        watchdogResetPulse,
  input wire logic        watchdogWakePulse,
  input wire logic        watchdogRunning
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_held;
    oscStartupTimerRunning [*3];
  endsequence
  sequence s_cfg_on;
    (configWatchdogEnable && !oscStartupTimerRunning && !oscFailDetect) [*3];
  endsequence

  a_bus_answer: assert property (s_taken |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_rdata_idle: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("read data not zero outside answer");
  a_reset_single: assert property (watchdogResetPulse |=> !watchdogResetPulse)
    else $error("reset event longer than one cycle");
  a_wake_single: assert property (watchdogWakePulse |=> !watchdogWakePulse)
    else $error("wake event longer than one cycle");
  a_startup_hold: assert property (s_held |-> !watchdogRunning && !watchdogResetPulse)
    else $error("watchdog active during start-up count");
  a_cfg_runs: assert property (s_cfg_on |-> watchdogRunning)
    else $error("config enable does not keep watchdog running");
  a_stopped_quiet: assert property (!watchdogRunning [*4] |-> !watchdogResetPulse)
    else $error("time-out while stopped");
  a_awake_reset: assert property (watchdogResetPulse |-> !$past(sleepActive))
    else $error("reset event while asleep");
endmodule

bind wdt_timer wdt_timer_properties i_props (
  .clock(clock), .srst(srst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .configWatchdogEnable(configWatchdogEnable), .oscFailDetect(oscFailDetect),
  .oscStartupTimerRunning(oscStartupTimerRunning), .sleepActive(sleepActive),
  .watchdogResetPulse(watchdogResetPulse), .watchdogWakePulse(watchdogWakePulse),
  .watchdogRunning(watchdogRunning));

/* File: dv/wdt_timer_tb.sv */
// Self-checking bench of the watchdog block: bus, enables, hold, time-out.
// Assumes the design answers each bus request a cycle after taking it.
`timescale 1ns/1ps
module wdt_timer_tb;
  import wdt_pkg::*;
  logic        clock = 0, srst = 1, rd = 0, wr = 0, waitReq, irq;
  logic        cfgEn = 0, clr = 0, oscFail = 0, wake = 0, osc_startup_timer = 0, lfStab = 0;
  logic        rstPulse, wakePulse, running, t0Out;
  logic        t0Tick = 0;
  logic [4:0]  addr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [3:0]  be = 4'h0;
  logic [2:0]  mode = 3'h4;
  int          miscompares = 0, n_tests = 0, n;

  wdt_timer i_wdt_timer (.clock(clock), .srst(srst), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(waitReq), .irq(irq), .configWatchdogEnable(cfgEn),
    .clearWatchdogInstruction(clr), .oscFailDetect(oscFail), .sleepActive(1'b0),
    .wakeFromSleep(wake), .sysClockMode(mode), .oscStartupTimerRunning(osc_startup_timer),
    .lfOscStableFlag(lfStab), .generalTimerZeroTick(t0Tick),
    .generalTimerZeroPrescaledTick(t0Out), .watchdogResetPulse(rstPulse),
    .watchdogWakePulse(wakePulse), .watchdogRunning(running));

  initial begin
    forever #10 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] b);
    @(posedge clock);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdat <= {24'h0, d};
    be <= b;
    do @(posedge clock); while (waitReq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, 4'h1);
    chk(q, exp);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask

  task automatic t_reset;
    rdchk(ADDR_CTRL, 32'h08);
    rdchk(ADDR_OPTION, 32'hff);
    rdchk(5'h18, 32'h0);
    bus(1'b1, ADDR_CTRL, 8'h01, 4'h0);
    bus(1'b1, ADDR_CTRL, 8'he8, 4'h1);
    rdchk(ADDR_CTRL, 32'h08);
    chk(running, 1'b0);
    // Prescaler assigned to the watchdog: timer tick passes through one cycle later
    t0Tick <= 1'b1;
    cyc(1);
    t0Tick <= 1'b0;
    cyc(1);
    chk(t0Out, 1'b1);
    cyc(1);
    chk(t0Out, 1'b0);
  endtask

  task automatic t_enables;
    bus(1'b1, ADDR_CTRL, 8'h01, 4'h1);
    cyc(3);
    chk(running, 1'b1);
    bus(1'b1, ADDR_CTRL, 8'h00, 4'h1);
    cfgEn <= 1'b1;
    cyc(3);
    chk(running, 1'b1);
    bus(1'b1, ADDR_CTRL, 8'h00, 4'h1);
    cyc(3);
    chk(running, 1'b1);
    cfgEn <= 1'b0;
    cyc(3);
    chk(running, 1'b0);
  endtask

  task automatic t_startup;
    bus(1'b1, ADDR_CTRL, 8'h01, 4'h1);
    osc_startup_timer <= 1'b1;
    lfStab <= 1'b1;
    cyc(4);
    chk(running, 1'b0);
    rdchk(ADDR_STATUS, 32'h6);
    osc_startup_timer <= 1'b0;
    cyc(4);
    chk(running, 1'b1);
    rdchk(ADDR_STATUS, 32'h3);
  endtask

  // Three clear sources 10000 cycles apart; only the last one sets the time-out
  task automatic t_timeout;
    bus(1'b1, ADDR_OPTION, 8'hf7, 4'h1);
    rdchk(ADDR_OPTION, 32'hf7);
    bus(1'b1, ADDR_IRQ_MASK, 8'h01, 4'h1);
    cyc(10000);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(10000);
    oscFail <= 1'b1;
    cyc(1);
    oscFail <= 1'b0;
    cyc(10000);
    wake <= 1'b1;
    cyc(1);
    wake <= 1'b0;
    n = 0;
    while (rstPulse !== 1'b1 && n < 60000) begin
      @(posedge clock);
      n++;
    end
    chk(n >= 31 * LF_DIV_CYCLES && n <= 33 * LF_DIV_CYCLES + 8, 1'b1);
    chk(wakePulse, 1'b0);
    cyc(3);
    chk(irq, 1'b1);
    rdchk(ADDR_IRQ_STATUS, 32'h1);
    rdchk(ADDR_CTRL, 32'h08);
    bus(1'b1, ADDR_IRQ_STATUS, 8'h01, 4'h1);
    cyc(3);
    chk(irq, 1'b0);
  endtask

  task automatic print_verdict;
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    cyc(3);
    srst <= 1'b0;
    t_reset();
    t_enables();
    t_startup();
    t_timeout();
    print_verdict();
  end

  initial begin
    cyc(95000);
    miscompares++;
    print_verdict();
  end
endmodule
